// ==== rtl/dtc_defs.vh ====
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// special function register byte addresses
`define DTC_ADDR_CTRL      8'h88
`define DTC_ADDR_MODE      8'h89
`define DTC_ADDR_A_LOW     8'h8a
`define DTC_ADDR_B_LOW     8'h8b
`define DTC_ADDR_A_HIGH    8'h8c
`define DTC_ADDR_B_HIGH    8'h8d
`define DTC_ADDR_PWM       8'h91
`define DTC_ADDR_A_RL_LOW  8'hf2
`define DTC_ADDR_B_RL_LOW  8'hf3
`define DTC_ADDR_A_RL_HIGH 8'hf4
`define DTC_ADDR_B_RL_HIGH 8'hf5

// bit address block of the control register (bit addr = 88h + bit)
`define DTC_CTRL_BIT_BLOCK 5'h11

// control register fields
`define DTC_CTRL_B_OVF     7
`define DTC_CTRL_B_RUN     6
`define DTC_CTRL_A_OVF     5
`define DTC_CTRL_A_RUN     4
`define DTC_CTRL_B_EDGE    3
`define DTC_CTRL_B_TYPE    2
`define DTC_CTRL_A_EDGE    1
`define DTC_CTRL_A_TYPE    0

// mode register fields
`define DTC_MODE_B_GATE    7
`define DTC_MODE_B_SRC     6
`define DTC_MODE_B_M_HI    5
`define DTC_MODE_B_M_LO    4
`define DTC_MODE_A_GATE    3
`define DTC_MODE_A_SRC     2
`define DTC_MODE_A_M_HI    1
`define DTC_MODE_A_M_LO    0

// operating modes
`define DTC_M_VAR          2'h0
`define DTC_M_AR16         2'h1
`define DTC_M_AR8          2'h2
`define DTC_M_SPLIT        2'h3

// reset values
`define DTC_RST_CTRL       8'h00
`define DTC_RST_MODE       8'h00
`define DTC_RST_PWM        8'h24
`define DTC_RST_DATA       8'h00

// variable mode prescaler width in the low byte
`define DTC_PSC_BITS       5

`endif

// ==== rtl/dtc_pin_sync.v ====
`timescale 1ns/100ps
// three stage pin sampler with agreement filter and falling edge pulse
module dtc_pin_sync (
  input  wire clock,    // system clock
  input  wire sys_rst,  // synchronous reset, active high
  input  wire pin,      // asynchronous pin level
  output reg  level_q,  // filtered level
  output reg  fall_q    // one cycle pulse on accepted 1-to-0
);

  reg s1_q;  // metastability catcher, read by s2 only
  reg s2_q;  // second stage
  reg s3_q;  // third stage

  // shift chain; idle level is high so no false edge after reset
  always @(posedge clock) begin
    if (sys_rst) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      level_q <= 1'b1;
      fall_q  <= 1'b0;
    end else begin
      s1_q   <= pin;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      fall_q <= 1'b0;
      // change accepted only when stages two and three agree
      if (s2_q == s3_q) begin
        level_q <= s3_q;
        fall_q  <= level_q & ~s3_q;
      end
    end
  end

endmodule // dtc_pin_sync

// ==== rtl/dtc_timer_regs.v ====
`timescale 1ns/100ps
`include "dtc_defs.vh"

// Operation
// - overflow sets timer overflow flag
// - vectoring to handler clears overflow flag
// - run bit starts and halts timer
// - triggering edge sets external edge flag
// - processed interrupt clears external edge flag
// - type bit: falling edge or low level
// - gating requires pin high plus run
// - source bit: system clock or pin
// - reload pair unused in modes 0,2,3
// - separate 16-bit reload per timer
// - control and mode reset to zero
// - four mode encodings per timer
// - split mode: low byte A, high byte B
// - counter increments on pin falling edge
// - variable mode uses 5-bit prescaler
module dtc_timer_regs (
  input  wire       clock,                  // system clock, 125 MHz
  input  wire       sys_rst,                // synchronous reset, active high
  input  wire [7:0] sfr_addr,               // byte register address
  input  wire       sfr_wr,                 // byte write strobe
  input  wire       sfr_rd,                 // byte read strobe
  input  wire [7:0] sfr_wdata,              // byte write data
  output reg  [7:0] sfr_rdata,              // registered read data
  input  wire [7:0] bit_addr,               // bit address for bit access
  input  wire       bit_wr,                 // bit write strobe
  input  wire       bit_wdata,              // bit write value
  output wire       bit_rdata,              // addressed control bit
  input  wire       ack_timer_a,            // core vectors to timer a handler
  input  wire       ack_timer_b,            // core vectors to timer b handler
  input  wire       ack_ext_a,              // external a interrupt processed
  input  wire       ack_ext_b,              // external b interrupt processed
  input  wire       ext_irq_a_pin,          // external interrupt a pin
  input  wire       ext_irq_b_pin,          // external interrupt b pin
  input  wire       timer_a_input_pin,      // timer a count pin
  input  wire       timer_b_input_pin,      // timer b count pin
  output wire       timer_a_overflow_flag,  // timer a overflow flag
  output wire       timer_b_overflow_flag,  // timer b overflow flag
  output wire       ext_irq_a_edge_flag,    // external a request flag
  output wire       ext_irq_b_edge_flag,    // external b request flag
  output wire [7:0] timer_pwm_control       // pwm control byte, held only
);

  // step the count by one in modes 0..2; returns {overflow, high, low}
  function [16:0] count_step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    input [7:0] rhi;
    input [7:0] rlo;
    reg   [`DTC_PSC_BITS:0] psc;
    reg   [8:0]  h9;
    reg   [8:0]  l9;
    reg   [16:0] w17;
    begin
      psc = {1'b0, lo[`DTC_PSC_BITS-1:0]} + 1'b1;
      h9  = {1'b0, hi} + 9'h001;
      l9  = {1'b0, lo} + 9'h001;
      w17 = {1'b0, hi, lo} + 17'h00001;
      case (mode)
        // prescaler carry ticks the high byte
        `DTC_M_VAR: begin
          if (psc[`DTC_PSC_BITS])
            count_step = {h9[8], h9[7:0], lo[7:`DTC_PSC_BITS], psc[`DTC_PSC_BITS-1:0]};
          else
            count_step = {1'b0, hi, lo[7:`DTC_PSC_BITS], psc[`DTC_PSC_BITS-1:0]};
        end
        // 16-bit wrap reloads from the reload pair
        `DTC_M_AR16: begin
          if (w17[16])
            count_step = {1'b1, rhi, rlo};
          else
            count_step = w17;
        end
        // low byte wrap reloads from the high byte
        `DTC_M_AR8: begin
          if (l9[8])
            count_step = {1'b1, hi, hi};
          else
            count_step = {1'b0, hi, l9[7:0]};
        end
        default: begin
          count_step = {1'b0, hi, lo};
        end
      endcase
    end
  endfunction

  reg  [7:0] ctrl_q;   // timer_control
  reg  [7:0] ctrl_d;
  reg  [7:0] mode_q;   // timer_mode_select
  reg  [7:0] pwm_q;    // timer_pwm_control
  reg  [7:0] a_lo_q;   // timer_a_count_low
  reg  [7:0] a_lo_d;
  reg  [7:0] a_hi_q;   // timer_a_count_high
  reg  [7:0] a_hi_d;
  reg  [7:0] b_lo_q;   // timer_b_count_low
  reg  [7:0] b_lo_d;
  reg  [7:0] b_hi_q;   // timer_b_count_high
  reg  [7:0] b_hi_d;
  reg  [7:0] a_rl_q;   // timer_a_reload_low
  reg  [7:0] a_rh_q;   // timer_a_reload_high
  reg  [7:0] b_rl_q;   // timer_b_reload_low
  reg  [7:0] b_rh_q;   // timer_b_reload_high
  reg  [7:0] ctrl_w;   // control after software write
  reg        a_ovf;    // timer a overflow event this cycle
  reg        b_ovf;    // timer b overflow event this cycle
  reg  [16:0] a_nx;    // timer a stepped value
  reg  [16:0] b_nx;    // timer b stepped value
  reg  [8:0]  split_hi; // high byte of a in split mode

  wire irq_a_lvl;      // filtered external a level
  wire irq_a_fall;     // external a falling edge
  wire irq_b_lvl;      // filtered external b level
  wire irq_b_fall;     // external b falling edge
  wire tin_a_lvl;      // unused level of count pin a
  wire tin_a_fall;     // count pin a falling edge
  wire tin_b_lvl;      // unused level of count pin b
  wire tin_b_fall;     // count pin b falling edge

  // pin samplers, one per external input
  dtc_pin_sync u_sync_irq_a (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pin     (ext_irq_a_pin),
    .level_q (irq_a_lvl),
    .fall_q  (irq_a_fall)
  );

  dtc_pin_sync u_sync_irq_b (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pin     (ext_irq_b_pin),
    .level_q (irq_b_lvl),
    .fall_q  (irq_b_fall)
  );

  dtc_pin_sync u_sync_tin_a (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pin     (timer_a_input_pin),
    .level_q (tin_a_lvl),
    .fall_q  (tin_a_fall)
  );

  dtc_pin_sync u_sync_tin_b (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pin     (timer_b_input_pin),
    .level_q (tin_b_lvl),
    .fall_q  (tin_b_fall)
  );

  // mode register fields and control run bits
  wire [1:0] timer_a_mode = {mode_q[`DTC_MODE_A_M_HI], mode_q[`DTC_MODE_A_M_LO]};
  wire [1:0] timer_b_mode = {mode_q[`DTC_MODE_B_M_HI], mode_q[`DTC_MODE_B_M_LO]};
  wire timer_a_pin_gating   = mode_q[`DTC_MODE_A_GATE];
  wire timer_b_pin_gating   = mode_q[`DTC_MODE_B_GATE];
  wire timer_a_count_source = mode_q[`DTC_MODE_A_SRC];
  wire timer_b_count_source = mode_q[`DTC_MODE_B_SRC];
  wire timer_a_run          = ctrl_q[`DTC_CTRL_A_RUN];
  wire timer_b_run          = ctrl_q[`DTC_CTRL_B_RUN];
  wire a_split              = (timer_a_mode == `DTC_M_SPLIT);

  wire a_enable = timer_a_run & (~timer_a_pin_gating | irq_a_lvl);
  wire b_enable = timer_b_run & (~timer_b_pin_gating | irq_b_lvl);

  wire a_step = a_enable & (timer_a_count_source ? tin_a_fall : 1'b1);
  wire b_step = b_enable & (timer_b_count_source ? tin_b_fall : 1'b1)
                & (timer_b_mode != `DTC_M_SPLIT);

  // split high byte rides b run
  wire split_step = a_split & timer_b_run;

  // byte write and bit address decode
  wire wr_ctrl = sfr_wr & (sfr_addr == `DTC_ADDR_CTRL);
  wire wr_a_lo = sfr_wr & (sfr_addr == `DTC_ADDR_A_LOW);
  wire wr_a_hi = sfr_wr & (sfr_addr == `DTC_ADDR_A_HIGH);
  wire wr_b_lo = sfr_wr & (sfr_addr == `DTC_ADDR_B_LOW);
  wire wr_b_hi = sfr_wr & (sfr_addr == `DTC_ADDR_B_HIGH);
  wire bit_hit = (bit_addr[7:3] == `DTC_CTRL_BIT_BLOCK);

  reg bit_rd_q;  // bit read data, one cycle behind bit_addr

  // registered bit read so the data output leaves a flop, like the byte port
  always @(posedge clock) begin
    if (sys_rst)
      bit_rd_q <= 1'b0;
    else
      bit_rd_q <= bit_hit ? ctrl_q[bit_addr[2:0]] : 1'b0;
  end

  assign bit_rdata = bit_rd_q;

  // software view of the control register before hardware events
  always @* begin
    ctrl_w = ctrl_q;
    if (wr_ctrl)
      ctrl_w = sfr_wdata;
    else if (bit_wr & bit_hit)
      ctrl_w[bit_addr[2:0]] = bit_wdata;
  end

  // timer a count path
  always @* begin
    a_nx     = count_step(timer_a_mode, a_hi_q, a_lo_q, a_rh_q, a_rl_q);
    split_hi = {1'b0, a_hi_q} + 9'h001;
    a_lo_d   = a_lo_q;
    a_hi_d   = a_hi_q;
    a_ovf    = 1'b0;
    if (a_split) begin
      if (a_step) begin
        a_lo_d = a_lo_q + 8'h01;
        a_ovf  = (a_lo_q == 8'hff);
      end
      if (split_step)
        a_hi_d = split_hi[7:0];
    end else if (a_step) begin
      a_lo_d = a_nx[7:0];
      a_hi_d = a_nx[15:8];
      a_ovf  = a_nx[16];
    end
    // software write wins over counting
    if (wr_a_lo)
      a_lo_d = sfr_wdata;
    if (wr_a_hi)
      a_hi_d = sfr_wdata;
  end

  // timer b count path
  always @* begin
    // b uses its own reload pair
    b_nx   = count_step(timer_b_mode, b_hi_q, b_lo_q, b_rh_q, b_rl_q);
    b_lo_d = b_lo_q;
    b_hi_d = b_hi_q;
    b_ovf  = 1'b0;
    if (b_step) begin
      b_lo_d = b_nx[7:0];
      b_hi_d = b_nx[15:8];
      // overflow flag b owned by split high byte when a is split
      b_ovf  = b_nx[16] & ~a_split;
    end
    if (split_step & (a_hi_q == 8'hff))
      b_ovf = 1'b1;
    if (wr_b_lo)
      b_lo_d = sfr_wdata;
    if (wr_b_hi)
      b_hi_d = sfr_wdata;
  end

  // control flags: hardware set beats any clear in the same cycle
  always @* begin
    ctrl_d = ctrl_w;
    ctrl_d[`DTC_CTRL_A_OVF] = a_ovf | (ctrl_w[`DTC_CTRL_A_OVF] & ~ack_timer_a);
    ctrl_d[`DTC_CTRL_B_OVF] = b_ovf | (ctrl_w[`DTC_CTRL_B_OVF] & ~ack_timer_b);
    ctrl_d[`DTC_CTRL_A_EDGE] = (ctrl_q[`DTC_CTRL_A_TYPE] ? irq_a_fall : ~irq_a_lvl)
                               | (ctrl_w[`DTC_CTRL_A_EDGE] & ~ack_ext_a);
    ctrl_d[`DTC_CTRL_B_EDGE] = (ctrl_q[`DTC_CTRL_B_TYPE] ? irq_b_fall : ~irq_b_lvl)
                               | (ctrl_w[`DTC_CTRL_B_EDGE] & ~ack_ext_b);
  end

  // register state
  always @(posedge clock) begin
    if (sys_rst) begin
      ctrl_q <= `DTC_RST_CTRL;
      mode_q <= `DTC_RST_MODE;
      pwm_q  <= `DTC_RST_PWM;
      a_lo_q <= `DTC_RST_DATA;
      a_hi_q <= `DTC_RST_DATA;
      b_lo_q <= `DTC_RST_DATA;
      b_hi_q <= `DTC_RST_DATA;
      a_rl_q <= `DTC_RST_DATA;
      a_rh_q <= `DTC_RST_DATA;
      b_rl_q <= `DTC_RST_DATA;
      b_rh_q <= `DTC_RST_DATA;
    end else begin
      ctrl_q <= ctrl_d;
      a_lo_q <= a_lo_d;
      a_hi_q <= a_hi_d;
      b_lo_q <= b_lo_d;
      b_hi_q <= b_hi_d;
      if (sfr_wr & (sfr_addr == `DTC_ADDR_MODE))
        mode_q <= sfr_wdata;
      if (sfr_wr & (sfr_addr == `DTC_ADDR_PWM))
        pwm_q <= sfr_wdata;
      // reload regs only written by software
      if (sfr_wr & (sfr_addr == `DTC_ADDR_A_RL_LOW))
        a_rl_q <= sfr_wdata;
      if (sfr_wr & (sfr_addr == `DTC_ADDR_A_RL_HIGH))
        a_rh_q <= sfr_wdata;
      if (sfr_wr & (sfr_addr == `DTC_ADDR_B_RL_LOW))
        b_rl_q <= sfr_wdata;
      if (sfr_wr & (sfr_addr == `DTC_ADDR_B_RL_HIGH))
        b_rh_q <= sfr_wdata;
    end
  end

  // registered read port; unmapped addresses read zero
  always @(posedge clock) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `DTC_ADDR_CTRL:      sfr_rdata <= ctrl_q;
        `DTC_ADDR_MODE:      sfr_rdata <= mode_q;
        `DTC_ADDR_A_LOW:     sfr_rdata <= a_lo_q;
        `DTC_ADDR_B_LOW:     sfr_rdata <= b_lo_q;
        `DTC_ADDR_A_HIGH:    sfr_rdata <= a_hi_q;
        `DTC_ADDR_B_HIGH:    sfr_rdata <= b_hi_q;
        `DTC_ADDR_PWM:       sfr_rdata <= pwm_q;
        `DTC_ADDR_A_RL_LOW:  sfr_rdata <= a_rl_q;
        `DTC_ADDR_B_RL_LOW:  sfr_rdata <= b_rl_q;
        `DTC_ADDR_A_RL_HIGH: sfr_rdata <= a_rh_q;
        `DTC_ADDR_B_RL_HIGH: sfr_rdata <= b_rh_q;
        default:             sfr_rdata <= 8'h00;
      endcase
    end
  end

  // flag outputs straight from the control register
  assign timer_a_overflow_flag = ctrl_q[`DTC_CTRL_A_OVF];
  assign timer_b_overflow_flag = ctrl_q[`DTC_CTRL_B_OVF];
  assign ext_irq_a_edge_flag   = ctrl_q[`DTC_CTRL_A_EDGE];
  assign ext_irq_b_edge_flag   = ctrl_q[`DTC_CTRL_B_EDGE];
  assign timer_pwm_control     = pwm_q;

endmodule // dtc_timer_regs

// ==== verif/dtc_timer_regs_sva.sv ====
`timescale 1ns/100ps
// port level checks of the timer register block
module dtc_chk (
  input wire       clock,                 // system clock
  input wire       sys_rst,               // sync reset
  input wire [7:0] sfr_addr,              // byte address
  input wire       sfr_wr,                // byte write
  input wire       sfr_rd,                // byte read
  input wire [7:0] sfr_wdata,             // write data
  input wire [7:0] sfr_rdata,             // read data
  input wire [7:0] bit_addr,              // bit address
  input wire       bit_wr,                // bit write
  input wire       bit_rdata,             // bit read
  input wire       ack_timer_a,           // timer a ack
  input wire       ack_timer_b,           // timer b ack
  input wire       ack_ext_a,             // ext a ack
  input wire       timer_a_overflow_flag, // flag
  input wire       timer_b_overflow_flag, // flag
  input wire       ext_irq_a_edge_flag,   // flag
  input wire       ext_irq_b_edge_flag    // flag
);
  // any software write reaching the control byte
  wire ctl_w = (sfr_wr && sfr_addr == 8'h88) || (bit_wr && bit_addr[7:3] == 5'h11);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_rst; $fell(sys_rst) |-> sfr_rdata == 8'h00 && !(timer_a_overflow_flag || timer_b_overflow_flag
    || ext_irq_a_edge_flag || ext_irq_b_edge_flag); endproperty
  a_rst: assert property (p_rst) else $error("flags or read data not clear after reset");
  property p_a_clr; $fell(timer_a_overflow_flag) |-> $past(ack_timer_a || ctl_w); endproperty
  a_a_clr: assert property (p_a_clr) else $error("timer a flag fell without ack");
  property p_b_clr; $fell(timer_b_overflow_flag) |-> $past(ack_timer_b || ctl_w); endproperty
  a_b_clr: assert property (p_b_clr) else $error("timer b flag fell without ack");
  property p_e_clr; $fell(ext_irq_a_edge_flag) |-> $past(ack_ext_a || ctl_w); endproperty
  a_e_clr: assert property (p_e_clr) else $error("ext a flag fell without ack");
  property p_bit_out; bit_addr[7:3] != 5'h11 |=> !bit_rdata; endproperty
  a_bit_out: assert property (p_bit_out) else $error("bit read outside control byte");
  property p_bit_ovf; bit_addr == 8'h8d |=> bit_rdata == $past(timer_a_overflow_flag); endproperty
  a_bit_ovf: assert property (p_bit_ovf) else $error("bit read of timer a flag wrong");
  property p_rd_ctl; sfr_rd && sfr_addr == 8'h88 |=> sfr_rdata[7] == $past(timer_b_overflow_flag)
    && sfr_rdata[1] == $past(ext_irq_a_edge_flag); endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control read disagrees with flags");
  property p_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_mode; sfr_wr && sfr_addr == 8'h89 ##1 sfr_rd && sfr_addr == 8'h89
    |=> sfr_rdata == $past(sfr_wdata, 2); endproperty
  a_mode: assert property (p_mode) else $error("mode byte read back wrong");
endmodule // dtc_chk
bind dtc_timer_regs dtc_chk u_chk (.*);

// ==== verif/dtc_core_model.sv ====
`timescale 1ns/100ps
// core side of the register space
module dtc_core (
  input  wire        clock,     // system clock
  output logic [7:0] sfr_addr,  // byte address
  output logic       sfr_wr,    // byte write
  output logic       sfr_rd,    // byte read
  output logic [7:0] sfr_wdata, // write data
  input  wire  [7:0] sfr_rdata, // read data
  output logic [7:0] bit_addr,  // bit address
  output logic       bit_wr,    // bit write
  output logic       bit_wdata, // bit value
  output logic [3:0] ack        // vector acks
);
  logic [6:0] st = 7'h00; // all strobes in one place
  assign {sfr_wr, sfr_rd, bit_wr, ack} = st;
  initial begin
    {sfr_addr, sfr_wdata, bit_addr, bit_wdata} = 25'h0;
  end
  // raise strobe through one edge; it stays up until the next call or idle
  task go(input logic [6:0] s);
    st = s;
    @(posedge clock);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    {sfr_addr, sfr_wdata} = {a, d};
    go(7'h40);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    go(7'h20);
    d = sfr_rdata;
  endtask
  task bwr(input logic [7:0] a, input logic v);
    {bit_addr, bit_wdata} = {a, v};
    go(7'h10);
  endtask
  // vectoring acks flags
  task pulse(input int k);
    go(7'(1 << k));
  endtask
  // released lines except bit_wdata never keep last value
  task idle();
    st = 7'h00;
    sfr_addr = ~sfr_addr;
    sfr_wdata = ~sfr_wdata;
    bit_addr = (bit_addr == 8'h8d) ? 8'h00 : 8'h8d;
  endtask
endmodule // dtc_core

// ==== verif/test_dtc_timer_regs.sv ====
`timescale 1ns/100ps
// self checking bench for the timer register block
module test_dtc_timer_regs;
  logic        clock = 1'b0;   // system clock
  logic        sys_rst = 1'b1; // sync reset
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, bit_addr, pwm; // bus
  logic        sfr_wr, sfr_rd, bit_wr, bit_wdata, bit_rdata;  // strobes
  logic [3:0]  ack;            // vector acks
  logic [1:0]  eirq = 2'h3;    // ext pins
  logic [1:0]  tin = 2'h3;     // count pins, b held high
  logic [1:0]  ovf, edg;       // flags
  int          failures, comparisons; // tallies
  logic [31:0] seed = 32'd84383;      // xorshift state
  int          mdl [256];      // register model
  int          adr [$] = '{'h88, 'h89, 'h8a, 'h8b, 'h8c, 'h8d, 'h91, 'hf2, 'hf3, 'hf4, 'hf5, 'h90};
  logic [7:0]  d;              // last read
  int          n;              // edge count
  dtc_timer_regs DUT (.clock(clock), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr),
    .bit_wdata(bit_wdata), .bit_rdata(bit_rdata), .ack_timer_a(ack[0]), .ack_timer_b(ack[1]),
    .ack_ext_a(ack[2]), .ack_ext_b(ack[3]), .ext_irq_a_pin(eirq[0]), .ext_irq_b_pin(eirq[1]),
    .timer_a_input_pin(tin[0]), .timer_b_input_pin(tin[1]), .timer_a_overflow_flag(ovf[0]),
    .timer_b_overflow_flag(ovf[1]), .ext_irq_a_edge_flag(edg[0]), .ext_irq_b_edge_flag(edg[1]),
    .timer_pwm_control(pwm));
  dtc_core u_core (.*);
  always #4 clock = ~clock;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // write and track, unmapped place stays empty
  task wrm(input logic [7:0] a, input logic [7:0] v);
    u_core.wr(a, v);
    if (a != 8'h90) mdl[a] = v;
  endtask
  task rdc(input string s, input logic [7:0] a);
    u_core.rd(a, d);
    chk(s, d, mdl[a][7:0]);
  endtask
  // bounded wait on flags {edg, ovf}
  task waitf(input logic [3:0] sel);
    n = 0;
    u_core.idle();
    while (({edg, ovf} & sel) == 4'h0 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  // one wrap of timer a (b=0) or timer b (b=1) in reload mode m, then halt
  task ovf_run(input int b, input int m);
    logic [7:0] lo, hi;
    lo = rnd() & 8'h7f;
    hi = rnd() & 8'h7f;
    wrm(8'hf2 + b, m == 1 ? lo : ~lo);
    wrm(8'hf4 + b, hi);
    wrm(8'h8a + b, 8'hff);
    wrm(8'h8c + b, m == 1 ? 8'hff : hi);
    wrm(8'h89, m << (4 * b));
    u_core.bwr(8'h8c + 2 * b, 1'b1);
    waitf(4'(1 << b));
    // stopping edge still steps once
    u_core.bwr(8'h8c + 2 * b, 1'b0);
    mdl[8'h8a + b] = (m == 1 ? lo : hi) + 1;
    // the wrap loads the reload high byte (mode 1) or keeps it (mode 2)
    mdl[8'h8c + b] = hi;
    chk("overflow flag", 8'(ovf[b]), 8'h01);
    rdc("count low", 8'h8a + b);
    rdc("count high", 8'h8c + b);
    rdc("reload low", 8'hf2 + b);
    u_core.pulse(b);
    chk("flag after ack", 8'(ovf[b]), 8'h00);
  endtask
  task give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hang guard, far beyond the run
  initial begin
    #20000;
    failures++;
    give_verdict();
  end
  initial begin
    foreach (mdl[i]) mdl[i] = 0;
    mdl[8'h91] = 8'h24;
    cyc(8);
    sys_rst = 1'b0;
    foreach (adr[i]) rdc("reset value", adr[i]);
    $display("reset values done");
    // random fill, timers stay stopped
    foreach (adr[i]) if (adr[i] != 'h88) wrm(adr[i], rnd());
    foreach (adr[i]) rdc("read back", adr[i]);
    chk("pwm port", pwm, mdl[8'h91][7:0]);
    wrm(8'h89, rnd());
    rdc("mode", 8'h89);
    $display("register access done");
    for (int b = 0; b < 2; b++) for (int m = 1; m < 3; m++) ovf_run(b, m);
    $display("overflow runs done");
    // mode 0: five prescale bits carry into the high byte, top three hold
    wrm(8'h89, 8'h00);
    wrm(8'h8a, 8'hbe);
    wrm(8'h8c, 8'hff);
    u_core.bwr(8'h8c, 1'b1);
    waitf(4'h1);
    u_core.bwr(8'h8c, 1'b0);
    mdl[8'h8a] = 8'ha1;
    mdl[8'h8c] = 8'h00;
    chk("mode 0 flag", 8'(ovf[0]), 8'h01);
    rdc("mode 0 low", 8'h8a);
    rdc("mode 0 high", 8'h8c);
    u_core.pulse(0);
    // split: high byte of a rides b's run bit, timer b itself halted
    wrm(8'h89, 8'h33);
    wrm(8'h8a, 8'hfe);
    wrm(8'h8c, 8'hfe);
    for (int k = 1; k >= 0; k--) begin
      u_core.bwr(8'h8c + 2 * k, 1'b1);
      waitf(4'(1 << k));
      u_core.bwr(8'h8c + 2 * k, 1'b0);
      mdl[8'h8a + 2 * k] = 8'h01;
      chk("split flag", 8'(ovf[k]), 8'h01);
      chk("split other flag", 8'(ovf[1 - k]), 8'h00);
      rdc("split low", 8'h8a);
      rdc("split high", 8'h8c);
      u_core.pulse(k);
    end
    rdc("halted b low", 8'h8b);
    $display("mode 0 and split done");
    // pin counting, system clock ignored
    wrm(8'h89, 8'h05);
    wrm(8'h8a, 8'h00);
    u_core.bwr(8'h8c, 1'b1);
    n = rnd() % 4 + 3;
    mdl[8'h8a] = n;
    repeat (n) begin
      tin[0] = 1'b0;
      cyc(6);
      tin[0] = 1'b1;
      cyc(6);
    end
    u_core.bwr(8'h8c, 1'b0);
    rdc("pin count", 8'h8a);
    // gated by ext pin low
    eirq[0] = 1'b0;
    // let the low level pass the pin sampler before the run bit rises
    cyc(6);
    wrm(8'h89, 8'h09);
    wrm(8'h8a, 8'h00);
    u_core.bwr(8'h8c, 1'b1);
    cyc(10);
    u_core.bwr(8'h8c, 1'b0);
    rdc("gated count", 8'h8a);
    eirq[0] = 1'b1;
    cyc(6);
    u_core.bwr(8'h8c, 1'b1);
    cyc(10);
    u_core.bwr(8'h8c, 1'b0);
    // one step per clock from the edge after the run edge through the stopping edge
    mdl[8'h8a] = 8'h0b;
    rdc("open gate", 8'h8a);
    $display("counter and gating done");
    for (int k = 0; k < 2; k++) begin
      u_core.bwr(8'h88 + 2 * k, 1'b1);
      u_core.pulse(2 + k);
      chk("edge idle", 8'(edg[k]), 8'h00);
      eirq[k] = 1'b0;
      waitf(4'(4 << k));
      chk("edge seen", 8'(edg[k]), 8'h01);
      u_core.pulse(2 + k);
      // drop the ack so a stray re-set would show
      u_core.idle();
      cyc(8);
      chk("edge once", 8'(edg[k]), 8'h00);
      u_core.bwr(8'h88 + 2 * k, 1'b0);
      waitf(4'(4 << k));
      chk("level seen", 8'(edg[k]), 8'h01);
      eirq[k] = 1'b1;
      cyc(6);
      u_core.pulse(2 + k);
      chk("level clear", 8'(edg[k]), 8'h00);
    end
    $display("external flags done");
    give_verdict();
  end
endmodule // test_dtc_timer_regs
